// [core/sldw_host.v]
// host controller driving the serial line display link
// Summary of operation
// - all dummy bit positions are driven low.
// - line address 7 bits, first bit sent is least significant, first line is 1.
// - a whole line of pixels is always sent, never a partial line.
// - update command carries update flag high and clear flag low.
// - static command carries update flag low and clear flag low.
// - static mode may last forever if polarity toggles at least every second.
// - clear command carries update flag low and clear flag high.
// - positive and negative polarity intervals equal and each at most one second; with select low the host flips polarity once per transfer, with no timer.
// - with select strapped low, polarity flag alternates between transfers.
// - with select strapped high, the hardware pulse is toggled by the host.
// - hardware inversion pulse has a 50 percent duty cycle.
// - pulse rate stays below frame rate, between 1 and 60 Hz.
// - after power-up, host sends a clear command before anything else.
// - before power-down, clear panel, return levels to idle, then report done; with select strapped high the host keeps toggling the hardware pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sldw_defines.vh"
module sldw_host #(
  parameter INV_HALF_CYC  = `SLDW_INV_HALF_CYC,
  parameter SCLK_HALF_CYC = `SLDW_SCLK_HALF_CYC
) (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire       inversion_source_select,
  input  wire       cmd_valid,
  input  wire [1:0] cmd_kind,
  output reg        cmd_ready,
  input  wire [7:0] pix_data,
  input  wire       pix_valid,
  output wire       pix_ready,
  input  wire       power_down_req,
  output reg        power_down_done,
  output reg        serial_clk,
  output reg        serial_data,
  output reg        frame_select,
  output reg        hw_inversion_pulse,
  output reg        panel_on,
  output reg        busy
);
  localparam [1:0] CMD_UPDATE = 2'h0;
  localparam [1:0] CMD_STATIC = 2'h1;
  localparam [1:0] CMD_CLEAR  = 2'h2;
  localparam [2:0] ST_INIT  = 3'h0;
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_MODE  = 3'h2;
  localparam [2:0] ST_ADDR  = 3'h3;
  localparam [2:0] ST_PIX   = 3'h4;
  localparam [2:0] ST_DUMMY = 3'h5;
  localparam [2:0] ST_GAP   = 3'h6;
  localparam [2:0] ST_OFF   = 3'h7;
  localparam [15:0] HALF_CYC = SCLK_HALF_CYC[15:0];
  localparam [15:0] GAP_CYC  = `SLDW_FRAME_GAP_CYC;
  localparam [6:0]  LAST_LINE = `SLDW_LINE_COUNT;
  localparam [6:0]  MODE_END  = `SLDW_MODE_BITS - 1;
  localparam [6:0]  ADDR_END  = `SLDW_ADDR_BITS - 1;
  localparam [6:0]  PIX_END   = `SLDW_LINE_BITS - 1;
  localparam [6:0]  DUMMY_END = `SLDW_DUMMY_BITS - 1;

  reg  [2:0]  state;
  reg  [1:0]  kind;
  reg  [15:0] tick;
  reg         phase;
  reg  [6:0]  bit_idx;
  reg  [6:0]  line_addr;
  reg         pd_active;
  reg  [7:0]  pix_byte;
  reg         byte_loaded;
  reg         polarity;
  reg  [31:0] inv_count;
  reg         sel_s1;
  reg         sel_s2;
  reg         sel_s3;
  reg         sel;
  reg         pd_pending;
  wire [7:0]  fifo_data;
  wire        fifo_valid;
  wire        fifo_take;
  wire        half_done;
  wire        bit_end;

  sldw_fifo #(
    .WIDTH (`SLDW_FIFO_WIDTH),
    .DEPTH (`SLDW_FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_data   (pix_data),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  assign half_done = (tick == HALF_CYC - 16'h0001);
  assign bit_end   = half_done & phase;

  // strap is a pin: three stages, accept a change once the last two agree
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      sel_s3 <= 1'b0;
      sel    <= 1'b0;
    end
    else if (clk_en)
    begin
      sel_s1 <= inversion_source_select;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      if (sel_s2 == sel_s3)
      begin
        sel <= sel_s3;
      end
    end
  end

  // hardware inversion pulse: square wave, well under the 1 s interval bound
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      inv_count          <= 32'h00000000;
      hw_inversion_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!sel)
      begin
        inv_count          <= 32'h00000000;
        hw_inversion_pulse <= 1'b0;
      end
      else if (inv_count == INV_HALF_CYC[31:0] - 32'h00000001)
      begin
        inv_count          <= 32'h00000000;
        hw_inversion_pulse <= ~hw_inversion_pulse;
      end
      else
      begin
        inv_count <= inv_count + 32'h00000001;
      end
    end
  end

  // one pixel byte is pulled from the fifo each time the shifter empties
  assign fifo_take = (state == ST_PIX) & ~byte_loaded & fifo_valid & (kind == CMD_UPDATE);

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state           <= ST_INIT;
      kind            <= CMD_CLEAR;
      tick            <= 16'h0000;
      phase           <= 1'b0;
      bit_idx         <= 7'h00;
      line_addr       <= 7'h01;
      pd_active       <= 1'b0;
      pix_byte        <= 8'h00;
      byte_loaded     <= 1'b0;
      polarity        <= 1'b0;
      pd_pending      <= 1'b0;
      cmd_ready       <= 1'b0;
      power_down_done <= 1'b0;
      serial_clk      <= 1'b0;
      serial_data     <= 1'b0;
      frame_select    <= 1'b0;
      panel_on        <= 1'b0;
      busy            <= 1'b1;
    end
    else if (clk_en)
    begin
      if (power_down_req)
      begin
        pd_pending <= 1'b1;
      end
      if (fifo_take)
      begin
        pix_byte    <= fifo_data;
        byte_loaded <= 1'b1;
      end
      case (state)
        ST_INIT:
        begin
          kind      <= CMD_CLEAR;
          state     <= ST_MODE;
          tick      <= 16'h0000;
          phase     <= 1'b0;
          bit_idx   <= 7'h00;
          frame_select <= 1'b1;
        end
        ST_IDLE:
        begin
          busy <= 1'b0;
          if (pd_pending)
          begin
            pd_pending <= 1'b0;
            pd_active  <= 1'b1;
            panel_on   <= 1'b0;
            kind       <= CMD_CLEAR;
            cmd_ready  <= 1'b0;
            busy       <= 1'b1;
            frame_select <= 1'b1;
            state      <= ST_MODE;
            tick       <= 16'h0000;
            phase      <= 1'b0;
            bit_idx    <= 7'h00;
          end
          else if (cmd_valid && cmd_ready)
          begin
            kind         <= cmd_kind;
            cmd_ready    <= 1'b0;
            busy         <= 1'b1;
            frame_select <= 1'b1;
            state        <= ST_MODE;
            tick         <= 16'h0000;
            phase        <= 1'b0;
            bit_idx      <= 7'h00;
            line_addr    <= 7'h01;
          end
        end
        ST_MODE, ST_ADDR, ST_PIX, ST_DUMMY:
        begin
          if (state == ST_PIX && !byte_loaded)
          begin
            tick <= 16'h0000; // stall on an empty fifo with the clock low
          end
          else if (half_done)
          begin
            tick       <= 16'h0000;
            phase      <= ~phase;
            serial_clk <= ~phase;
          end
          else
          begin
            tick <= tick + 16'h0001;
          end
          // data changes at the start of each bit, while the clock is low
          if (tick == 16'h0000 && !phase && !(state == ST_PIX && !byte_loaded))
          begin
            case (state)
              ST_MODE:
              begin
                case (bit_idx[2:0])
                  `SLDW_FLAG_UPDATE:   serial_data <= (kind == CMD_UPDATE);
                  `SLDW_FLAG_POLARITY: serial_data <= sel ? 1'b0 : polarity;
                  `SLDW_FLAG_CLEAR:    serial_data <= (kind == CMD_CLEAR);
                  default:             serial_data <= 1'b0;
                endcase
              end
              ST_ADDR:  serial_data <= line_addr[bit_idx[2:0]];
              ST_PIX:   serial_data <= pix_byte[7 - bit_idx[2:0]];
              default:  serial_data <= 1'b0;
            endcase
          end
          if (bit_end)
          begin
            bit_idx <= bit_idx + 7'h01;
            if (state == ST_PIX && bit_idx[2:0] == 3'h7)
            begin
              byte_loaded <= 1'b0;
            end
            case (state)
              ST_MODE:
              begin
                if (bit_idx == MODE_END)
                begin
                  bit_idx <= 7'h00;
                  state   <= (kind == CMD_UPDATE) ? ST_ADDR : ST_DUMMY;
                end
              end
              ST_ADDR:
              begin
                if (bit_idx == ADDR_END)
                begin
                  bit_idx <= 7'h00;
                  state   <= ST_PIX; // pixel bits follow the address
                end
              end
              ST_PIX:
              begin
                if (bit_idx == PIX_END)
                begin
                  bit_idx <= 7'h00;
                  state   <= ST_DUMMY;
                end
              end
              default:
              begin
                if (bit_idx == DUMMY_END)
                begin
                  bit_idx <= 7'h00;
                  if (kind == CMD_UPDATE && line_addr != LAST_LINE)
                  begin
                    line_addr <= line_addr + 7'h01;
                    state     <= ST_ADDR;
                  end
                  else
                  begin
                    state <= ST_GAP;
                    tick  <= 16'h0000;
                  end
                end
              end
            endcase
          end
        end
        ST_GAP:
        begin
          // frame ends only after the trailing dummies, never mid-line
          frame_select <= 1'b0;
          serial_data  <= 1'b0;
          serial_clk   <= 1'b0;
          if (tick == GAP_CYC - 16'h0001)
          begin
            tick     <= 16'h0000;
            polarity <= ~polarity;
            state    <= pd_active ? ST_OFF : ST_IDLE;
          end
          else
          begin
            tick <= tick + 16'h0001;
          end
        end
        ST_OFF:
        begin
          power_down_done <= 1'b1;
          panel_on        <= 1'b0;
          busy            <= 1'b0;
          cmd_ready       <= 1'b0;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
      if (state == ST_GAP && tick == GAP_CYC - 16'h0001 && !pd_active)
      begin
        panel_on  <= 1'b1;
        cmd_ready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [core/sldw_defines.vh]
// shared constants for the serial line display writer
`ifndef SLDW_DEFINES_VH
`define SLDW_DEFINES_VH
`define SLDW_LINE_BITS      96
`define SLDW_LINE_COUNT     96
`define SLDW_ADDR_BITS      7
`define SLDW_MODE_BITS      8
`define SLDW_DUMMY_BITS     8
`define SLDW_FLAG_UPDATE    0
`define SLDW_FLAG_POLARITY  1
`define SLDW_FLAG_CLEAR     2
`define SLDW_CLK_MHZ        250
`define SLDW_SCLK_HALF_NS   500
`define SLDW_SCLK_HALF_CYC  ((`SLDW_SCLK_HALF_NS * `SLDW_CLK_MHZ + 999) / 1000)
`define SLDW_FRAME_GAP_NS   2000
`define SLDW_FRAME_GAP_CYC  ((`SLDW_FRAME_GAP_NS * `SLDW_CLK_MHZ + 999) / 1000)
`define SLDW_INV_HALF_MS    500
`define SLDW_INV_HALF_CYC   (`SLDW_INV_HALF_MS * `SLDW_CLK_MHZ * 1000)
`define SLDW_FIFO_DEPTH     32
`define SLDW_FIFO_WIDTH     8
`endif

// [core/sldw_fifo.v]
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sldw_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             core_clk,
  input  wire             reset,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg             not_full;
  wire            do_wr;
  wire            do_rd;

  // ready is kept in a flop so the port never comes through logic
  assign in_ready  = not_full;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = clk_en & in_valid & in_ready;
  assign do_rd     = clk_en & out_valid & out_ready;

  always @(posedge core_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      not_full <= 1'b1;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd)
      begin
        count    <= count + 1'b1;
        not_full <= (count != DEPTH[AW:0] - 1'b1);
      end
      else if (do_rd & ~do_wr)
      begin
        count    <= count - 1'b1;
        not_full <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/sldw_checker.sv]
// port assertions for the serial line display host
`timescale 1ns/1ps
`default_nettype none
module sldw_checker #(
  parameter INV_HALF_CYC  = 2000,
  parameter SCLK_HALF_CYC = 125
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic inversion_source_select,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic power_down_done,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic frame_select,
  input wire logic hw_inversion_pulse,
  input wire logic busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  int   hi_cnt     = 0;
  int   pulse_cnt  = 0;
  logic pulse_q    = 1'b0;
  logic pulse_seen = 1'b0;
  // spacing is only judged between two toggles, never from the strap change
  always @(posedge core_clk)
  begin
    // frozen cycles are not counted, the host does not advance in them
    if (clk_en)
    begin
      pulse_q   <= hw_inversion_pulse;
      hi_cnt    <= serial_clk ? hi_cnt + 1 : 0;
      pulse_cnt <= (pulse_q != hw_inversion_pulse) ? 1 : pulse_cnt + 1;
    end
    pulse_seen <= !reset && inversion_source_select
                  && (pulse_seen || pulse_q != hw_inversion_pulse);
  end
  sequence s_take;
    clk_en && cmd_valid && cmd_ready;
  endsequence
  sequence s_pulse_edge;
    clk_en && pulse_seen && (pulse_q != hw_inversion_pulse);
  endsequence
  a_clk_idle_low: assert property (!frame_select |-> !serial_clk)
    else $error("serial clock moves outside a frame");
  a_frame_opens_low: assert property ($rose(frame_select) |-> !serial_clk && busy)
    else $error("frame opened with clock high or while idle");
  a_data_steady: assert property (serial_clk && $past(serial_clk) |-> $stable(serial_data))
    else $error("serial data changed while clock high");
  a_sclk_high_len: assert property ($fell(serial_clk) |-> hi_cnt == SCLK_HALF_CYC)
    else $error("serial clock high phase too short");
  a_cmd_starts_work: assert property (s_take |-> ##[1:2] busy)
    else $error("accepted command did not start work");
  a_done_quiet: assert property (power_down_done |-> !frame_select && !busy)
    else $error("power down reported while link active");
  a_soft_pulse_still: assert property (!inversion_source_select && $past(!inversion_source_select)
    |-> $stable(hw_inversion_pulse))
    else $error("inversion pulse toggles in software mode");
  a_pulse_half: assert property (s_pulse_edge |-> pulse_cnt == INV_HALF_CYC)
    else $error("inversion pulse half period wrong");
endmodule
bind sldw_host sldw_checker #(.INV_HALF_CYC(INV_HALF_CYC), .SCLK_HALF_CYC(SCLK_HALF_CYC)) u_chk (
  .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .inversion_source_select(inversion_source_select),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .power_down_done(power_down_done),
  .serial_clk(serial_clk), .serial_data(serial_data), .frame_select(frame_select),
  .hw_inversion_pulse(hw_inversion_pulse), .busy(busy)
);
`default_nettype wire

// [dv/sldw_panel_model.sv]
// behavioural panel answering the host controller's serial link
`timescale 1ns/1ps
`default_nettype none
module sldw_panel_model (
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic frame_select,
  input wire logic hw_inversion_pulse,
  input wire logic panel_on,
  input wire logic inversion_source_select
);
  logic [95:0] mem [0:95];
  logic [95:0] pix;
  logic [6:0]  addr;
  logic [7:0]  mode;
  logic [2:0]  first_mode, last_mode;
  logic        pol_last, pol_prev, com;
  logic        toggle_latch = 1'b0;
  int          bitn = 0, p, i, frames = 0, lines = 0, bad_dummy = 0, rises = 0;
  wire logic [95:0] shown_top = panel_on ? mem[0] : '1;
  initial
    for (i = 0; i < 96; i++) mem[i] = '0;
  always @(posedge frame_select) bitn = 0;
  always @(posedge serial_clk)
    if (frame_select)
    begin
      p = (bitn - 8) % 111;
      if (bitn < 8) mode[bitn] = serial_data;
      else if (p < 7) addr[p] = serial_data;
      else if (p < 103) pix[102 - p] = serial_data;
      if (((bitn >= 3 && bitn < 8) || (bitn >= 8 && p >= 103)) && serial_data) bad_dummy++;
      if (bitn == 2 && !inversion_source_select) com = mode[1];
      // a line lands only once its last dummy bit is in, so a cut line is lost
      if (bitn >= 8 && p == 110 && mode[0] && !mode[2] && addr >= 1 && addr <= 96)
      begin
        mem[addr - 1] = pix;
        lines++;
      end
      bitn++;
    end
  always @(negedge frame_select)
    if (bitn >= 3)
    begin
      if (mode[2] && !mode[0])
        for (i = 0; i < 96; i++) mem[i] = '1;
      if (inversion_source_select) com = toggle_latch;
      if (frames == 0) first_mode = mode[2:0];
      pol_prev  = pol_last;
      pol_last  = mode[1];
      last_mode = mode[2:0];
      frames++;
    end
  always @(posedge hw_inversion_pulse)
    if (panel_on && inversion_source_select)
    begin
      toggle_latch = !toggle_latch;
      rises++;
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the serial line display host
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int         INV   = 2000;
  localparam int         NB    = 1152;
  // command codes as the host decodes them
  localparam logic [1:0] K_UPD = 2'h0;
  localparam logic [1:0] K_STA = 2'h1;
  localparam logic [1:0] K_CLR = 2'h2;
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        sel       = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_kind  = 2'h0;
  logic [7:0]  pix_data  = 8'h00;
  logic        pix_valid = 1'b0;
  logic        pd_req    = 1'b0;
  logic        clk_en    = 1'b1;
  logic        held;
  logic        cmd_ready, pix_ready, pd_done, sclk, sdata, fsel, pulse, pon, busy;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [95:0] exp_line;
  always #2 core_clk = ~core_clk;
  // a fast link clock keeps a full 96-line frame well inside the run budget
  sldw_host #(.INV_HALF_CYC(INV), .SCLK_HALF_CYC(2)) u_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .inversion_source_select(sel),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready), .pix_data(pix_data),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .power_down_req(pd_req),
    .power_down_done(pd_done), .serial_clk(sclk), .serial_data(sdata), .frame_select(fsel),
    .hw_inversion_pulse(pulse), .panel_on(pon), .busy(busy)
  );
  sldw_panel_model u_pm (
    .serial_clk(sclk), .serial_data(sdata), .frame_select(fsel),
    .hw_inversion_pulse(pulse), .panel_on(pon), .inversion_source_select(sel)
  );
  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send_cmd(input logic [1:0] kind);
    @(negedge core_clk);
    cmd_kind  = kind;
    cmd_valid = 1'b1;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic feed();
    for (int k = 0; k < NB; k++)
    begin
      @(negedge core_clk);
      pix_data  = 8'(k * 7 + 3);
      pix_valid = 1'b1;
      do @(posedge core_clk); while (pix_ready !== 1'b1);
    end
    @(negedge core_clk);
    pix_valid = 1'b0;
  endtask
  // busy may take a couple of cycles to rise after a command is taken
  task automatic wait_idle();
    repeat (4) @(negedge core_clk);
    while (busy !== 1'b0) @(negedge core_clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    wait_idle();
    chk("first mode", 96'h4, 96'(u_pm.first_mode & 3'h5));
    chk("white after start", '1, u_pm.mem[95]);
    fork
      feed();
      send_cmd(K_UPD);
    join
    wait_idle();
    chk("lines written", 96'd96, 96'(u_pm.lines));
    for (int n = 0; n < 96; n++)
    begin
      for (int b = 0; b < 12; b++) exp_line = {exp_line[87:0], 8'((n * 12 + b) * 7 + 3)};
      chk("line data", exp_line, u_pm.mem[n]);
    end
    send_cmd(K_STA);
    wait_idle();
    send_cmd(K_STA);
    wait_idle();
    chk("static mode", 96'h0, 96'(u_pm.last_mode & 3'h5));
    chk("polarity swap", 96'h1, 96'(u_pm.pol_last ^ u_pm.pol_prev));
    chk("line kept", exp_line, u_pm.mem[95]);
    sel = 1'b1;
    repeat (3 * INV) @(negedge core_clk);
    clk_en = 1'b0;
    held   = pulse;
    repeat (2 * INV) @(negedge core_clk);
    chk("frozen pulse", 96'(held), 96'(pulse));
    clk_en = 1'b1;
    send_cmd(K_STA);
    wait_idle();
    send_cmd(K_STA);
    wait_idle();
    chk("flag sent low", 96'h0, 96'(u_pm.pol_last | u_pm.pol_prev));
    chk("pulse rises", 96'h1, 96'(u_pm.rises > 0));
    send_cmd(K_CLR);
    wait_idle();
    chk("cleared line", '1, u_pm.mem[40]);
    @(negedge core_clk);
    pd_req = 1'b1;
    while (pd_done !== 1'b1) @(negedge core_clk);
    pd_req = 1'b0;
    chk("panel off", 96'h0, 96'(pon));
    chk("white when off", '1, u_pm.shown_top);
    chk("dummy bits", 96'h0, 96'(u_pm.bad_dummy));
    end_of_test();
  end
  // the whole run needs about 60 thousand cycles at this link rate
  initial
  begin
    repeat (95000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
